// ---- rtl/gcn_pkg.sv ----
package gcn_pkg;

  // ==========================================================================
  // Widths and types
  localparam int unsigned NUM_PORTS = 6;
  localparam int unsigned PORT_W    = 16;
  localparam int unsigned CN_W      = 24;
  localparam int unsigned IDX_W     = 10;
  localparam int unsigned ADDR_W    = 12;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] gcn_port_vec_t;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CN_EN_LO = 10'h0C0;
  localparam logic [IDX_W-1:0] IDX_CN_EN_HI = 10'h0C2;
  localparam logic [IDX_W-1:0] IDX_CN_PU_LO = 10'h0C4;
  localparam logic [IDX_W-1:0] IDX_CN_PU_HI = 10'h0C6;
  localparam logic [IDX_W-1:0] IDX_CN_STAT  = 10'h0C8;
  localparam logic [IDX_W-1:0] IDX_ANA_SEL  = 10'h0CA;

  // Port order, right to left: A, B, C, D, F, G
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] DIR_IDX =
    {10'h2E4, 10'h2DE, 10'h2D2, 10'h2CC, 10'h2C6, 10'h2C0};
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] PIN_IDX =
    {10'h2E6, 10'h2E0, 10'h2D4, 10'h2CE, 10'h2C8, 10'h2C2};
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] LAT_IDX =
    {10'h2E8, 10'h2E2, 10'h2D6, 10'h2D0, 10'h2CB, 10'h2C4};

  // ==========================================================================
  // Implemented bits; also the direction value after reset
  localparam gcn_port_vec_t MASK_LARGE =
    {16'hF3CF, 16'h01FF, 16'hFFFF, 16'hE01E, 16'hFFFF, 16'hF6C0};
  localparam gcn_port_vec_t MASK_SMALL =
    {16'hF3CF, 16'h007F, 16'h0FFF, 16'hE006, 16'hFFFF, 16'h0000};
  localparam logic [7:0]    CN_HI_MASK_LARGE = 8'hFF;
  localparam logic [7:0]    CN_HI_MASK_SMALL = 8'h07;
  localparam logic [PORT_W-1:0] LAT_RESET    = 16'h0000;
  localparam logic [PORT_W-1:0] CN_RESET     = 16'h0000;

  // Port whose pins double as converter inputs
  localparam int unsigned ANALOG_PORT = 1;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/gcn_cn_if.sv ----
`timescale 1ns/10ps
interface gcn_cn_if;
  logic [gcn_pkg::CN_W-1:0] en;
  logic [gcn_pkg::CN_W-1:0] sync_in;
  logic [gcn_pkg::CN_W-1:0] raw_in;
  logic                     sleep;
  logic                     ack;
  logic                     irq;
  logic                     wake;

  modport ctl (output en, sync_in, raw_in, sleep, ack, input irq, wake);
  modport det (input en, sync_in, raw_in, sleep, ack, output irq, wake);
endinterface

// ---- rtl/gcn_sync.sv ----
`timescale 1ns/10ps
module gcn_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] din,
  output wire logic [W-1:0] dout
);
  // ==========================================================================
  // Two stages; the first stage feeds only the second
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge aclk)
  begin
    s1_q <= din;
    s2_q <= s1_q;
  end

  assign dout = s2_q;

  // Stages hold no reset value, so the check starts once two post-reset inputs have passed through
  sync_delay_a : assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> dout == $past(din, 2))
    else $error("synchroniser output is not its input two edges late");
endmodule // gcn_sync

// ---- rtl/gcn_change_detect.sv ----
`timescale 1ns/10ps
module gcn_change_detect (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Change inputs and request
  gcn_cn_if.det     bus
);
  // ==========================================================================
  // Reference levels
  logic [gcn_pkg::CN_W-1:0] ref_q;
  logic                     irq_q;
  logic                     wake_q;
  logic                     change_hit;
  logic                     async_change;

  // Reference freezes in sleep so the wake compare has something to hold to
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_q <= '0;
    else if (!bus.sleep)
      ref_q <= bus.sync_in;
  end

  assign change_hit = |(bus.en & (bus.sync_in ^ ref_q));

  // ==========================================================================
  // Request flag; a new change wins over the acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else if (change_hit)
      irq_q <= 1'b1;
    else if (bus.ack)
      irq_q <= 1'b0;
  end

  // ==========================================================================
  // Clockless wake path: raw pads against the frozen reference
  assign async_change = bus.sleep & |(bus.en & (bus.raw_in ^ ref_q));

  always_ff @(posedge aclk or posedge async_change)
  begin
    if (async_change)
      wake_q <= 1'b1;
    else if (!aresetn || !bus.sleep)
      wake_q <= 1'b0;
  end

  assign bus.irq  = irq_q;
  assign bus.wake = wake_q;

  // ==========================================================================
  // Checks
  irq_set_a : assert property (@(posedge aclk) disable iff (!aresetn) change_hit |=> irq_q)
    else $error("change seen but no request raised");
  irq_hold_a : assert property (@(posedge aclk) disable iff (!aresetn) irq_q && !bus.ack |=> irq_q)
    else $error("request dropped without acknowledge");
  irq_clear_a : assert property (@(posedge aclk) disable iff (!aresetn)
    irq_q && bus.ack && !change_hit |=> !irq_q)
    else $error("acknowledge did not clear request");
  sleep_wake_a : assert property (@(posedge aclk) disable iff (!aresetn)
    bus.sleep && async_change |=> wake_q)
    else $error("change in sleep did not raise wake");
  irq_seen_c : cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_q));
  wake_seen_c : cover property (@(posedge aclk) disable iff (!aresetn) $rose(wake_q));
endmodule // gcn_change_detect

// ---- rtl/gcn_top.sv ----
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
module gcn_top #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Register bus, write
  input  wire logic                         awvalid,
  output wire logic                         awready,
  input  wire logic [gcn_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                         wvalid,
  output wire logic                         wready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  output wire logic                         bvalid,
  input  wire logic                         bready,
  output wire logic [1:0]                   bresp,
  // Register bus, read
  input  wire logic                         arvalid,
  output wire logic                         arready,
  input  wire logic [gcn_pkg::ADDR_W-1:0]   araddr,
  output wire logic                         rvalid,
  input  wire logic                         rready,
  output wire logic [31:0]                  rdata,
  output wire logic [1:0]                   rresp,
  // Pads
  input  wire gcn_pkg::gcn_port_vec_t       pad_in,
  output wire gcn_pkg::gcn_port_vec_t       pad_out,
  output wire gcn_pkg::gcn_port_vec_t       pad_oe_n,
  // Peripherals sharing the pads
  input  wire gcn_pkg::gcn_port_vec_t       periph_drive,
  input  wire gcn_pkg::gcn_port_vec_t       periph_out,
  // Change notification
  input  wire logic [gcn_pkg::CN_W-1:0]     cn_pad_in,
  input  wire logic                         sleep_mode,
  output wire logic [gcn_pkg::CN_W-1:0]     cn_pullup_en,
  output wire logic                         cn_irq,
  output wire logic                         cn_wake,
  // Converter side
  output wire logic [gcn_pkg::PORT_W-1:0]   adc_chan_en,
  output wire logic [gcn_pkg::PORT_W-1:0]   adc_level
);

  // ==========================================================================
  // Declarations
  localparam int unsigned NP = gcn_pkg::NUM_PORTS;
  localparam int unsigned AP = gcn_pkg::ANALOG_PORT;
  localparam logic [7:0]  CN_HI_MASK = SMALL_VARIANT ? gcn_pkg::CN_HI_MASK_SMALL : gcn_pkg::CN_HI_MASK_LARGE;

  logic                        awready_q;
  logic                        wready_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        arready_q;
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  logic                        aw_held_q;
  logic                        w_held_q;
  logic [gcn_pkg::IDX_W-1:0]   wr_idx_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        do_write;
  logic [gcn_pkg::IDX_W-1:0]   rd_idx;
  logic [31:0]                 rd_data_d;
  logic                        rd_err_d;
  logic                        wr_err;
  logic                        cn_wr_hit;
  logic                        cn_rd_hit;
  logic [15:0]                 cn_en_lo_q;
  logic [7:0]                  cn_en_hi_q;
  logic [15:0]                 cn_pu_lo_q;
  logic [7:0]                  cn_pu_hi_q;
  logic [15:0]                 analog_q;
  logic [15:0]                 adc_level_q;
  logic [15:0]                 rd_an_q;
  logic [15:0]                 drive_b;
  gcn_pkg::gcn_port_vec_t      dir_q;
  gcn_pkg::gcn_port_vec_t      lat_q;
  gcn_pkg::gcn_port_vec_t      pad_out_q;
  gcn_pkg::gcn_port_vec_t      pad_oe_n_q;
  gcn_pkg::gcn_port_vec_t      mask_w;
  gcn_pkg::gcn_port_vec_t      pin_sync_w;
  gcn_pkg::gcn_port_vec_t      rd_val_w;
  logic [NP-1:0]               rd_hit_w;
  logic [NP-1:0]               wr_hit_w;
  logic [gcn_pkg::CN_W-1:0]    cn_sync_w;
  gcn_cn_if                    cn_bus ();

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================================
  // Synchronisers for all pad inputs
  gcn_sync #(
    .W (NP * gcn_pkg::PORT_W + gcn_pkg::CN_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({cn_pad_in, pad_in}),
    .dout    ({cn_sync_w, pin_sync_w})
  );

  // ==========================================================================
  // Write channels; address and data are taken in either order
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b0;
      wr_idx_q  <= '0;
    end
    else
    begin
      awready_q <= !((awvalid && awready_q) || (aw_held_q && !do_write));
      if (awvalid && awready_q)
      begin
        aw_held_q <= 1'b1;
        wr_idx_q  <= awaddr[gcn_pkg::ADDR_W-1:2];
      end
      else if (do_write)
        aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b0;
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else
    begin
      wready_q <= !((wvalid && wready_q) || (w_held_q && !do_write));
      if (wvalid && wready_q)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  assign cn_wr_hit = wr_idx_q inside {gcn_pkg::IDX_CN_EN_LO, gcn_pkg::IDX_CN_EN_HI, gcn_pkg::IDX_CN_PU_LO,
                                      gcn_pkg::IDX_CN_PU_HI, gcn_pkg::IDX_CN_STAT, gcn_pkg::IDX_ANA_SEL};
  assign wr_err    = !cn_wr_hit && !(|wr_hit_w);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= gcn_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? gcn_pkg::RESP_SLVERR : gcn_pkg::RESP_OKAY;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // ==========================================================================
  // Change notification and converter select registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cn_en_lo_q <= gcn_pkg::CN_RESET;
      cn_en_hi_q <= gcn_pkg::CN_RESET[7:0];
      cn_pu_lo_q <= gcn_pkg::CN_RESET;
      cn_pu_hi_q <= gcn_pkg::CN_RESET[7:0];
      analog_q   <= '0;
    end
    else if (do_write)
    begin
      case (wr_idx_q)
        gcn_pkg::IDX_CN_EN_LO: cn_en_lo_q <= merge16(cn_en_lo_q, wdata_q, wstrb_q);
        gcn_pkg::IDX_CN_EN_HI: cn_en_hi_q <= (wstrb_q[0] ? wdata_q[7:0] : cn_en_hi_q) & CN_HI_MASK;
        gcn_pkg::IDX_CN_PU_LO: cn_pu_lo_q <= merge16(cn_pu_lo_q, wdata_q, wstrb_q);
        gcn_pkg::IDX_CN_PU_HI: cn_pu_hi_q <= (wstrb_q[0] ? wdata_q[7:0] : cn_pu_hi_q) & CN_HI_MASK;
        gcn_pkg::IDX_ANA_SEL:  analog_q   <= merge16(analog_q, wdata_q, wstrb_q) & mask_w[AP];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Ports: direction, latch, pad drive and read values
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    logic [15:0] pin_rd;
    logic        rd_dir;
    logic        rd_pin;
    logic        rd_lat;
    logic        wr_dir;
    logic        wr_lat;

    assign mask_w[p] = SMALL_VARIANT ? gcn_pkg::MASK_SMALL[p] : gcn_pkg::MASK_LARGE[p];
    assign pin_rd    = pin_sync_w[p] & mask_w[p] & ((p == AP) ? ~analog_q : 16'hFFFF);
    assign rd_dir    = rd_idx == gcn_pkg::DIR_IDX[p];
    assign rd_pin    = rd_idx == gcn_pkg::PIN_IDX[p];
    assign rd_lat    = rd_idx == gcn_pkg::LAT_IDX[p];
    assign wr_dir    = wr_idx_q == gcn_pkg::DIR_IDX[p];
    assign wr_lat    = (wr_idx_q == gcn_pkg::LAT_IDX[p]) || (wr_idx_q == gcn_pkg::PIN_IDX[p]);
    assign wr_hit_w[p] = wr_dir || wr_lat;
    assign rd_hit_w[p] = rd_dir || rd_pin || rd_lat;
    assign rd_val_w[p] = rd_dir ? dir_q[p] : (rd_pin ? pin_rd : (rd_lat ? lat_q[p] : 16'h0000));

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        dir_q[p] <= mask_w[p];
      else if (do_write && wr_dir)
        dir_q[p] <= merge16(dir_q[p], wdata_q, wstrb_q) & mask_w[p];
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        lat_q[p] <= gcn_pkg::LAT_RESET;
      else if (do_write && wr_lat)
        lat_q[p] <= merge16(lat_q[p], wdata_q, wstrb_q) & mask_w[p];
    end

    // Peripheral drive overrides the port; the pin stays readable
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pad_out_q[p]  <= '0;
        pad_oe_n_q[p] <= 16'hFFFF;
      end
      else
      begin
        pad_out_q[p]  <= (periph_out[p] & periph_drive[p]) | (lat_q[p] & ~periph_drive[p]);
        pad_oe_n_q[p] <= ~(periph_drive[p] | (~dir_q[p] & mask_w[p]));
      end
    end
  end

  // ==========================================================================
  // Converter level: sampled pin when input, driven level when output
  assign drive_b = (periph_out[AP] & periph_drive[AP]) | (lat_q[AP] & ~periph_drive[AP]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_level_q <= '0;
    else
      adc_level_q <= analog_q & ((dir_q[AP] & pin_sync_w[AP]) | (~dir_q[AP] & drive_b));
  end

  // ==========================================================================
  // Read channel
  assign rd_idx    = araddr[gcn_pkg::ADDR_W-1:2];
  assign cn_rd_hit = rd_idx inside {gcn_pkg::IDX_CN_EN_LO, gcn_pkg::IDX_CN_EN_HI, gcn_pkg::IDX_CN_PU_LO,
                                    gcn_pkg::IDX_CN_PU_HI, gcn_pkg::IDX_CN_STAT, gcn_pkg::IDX_ANA_SEL};

  always_comb
  begin
    rd_data_d = '0;
    rd_err_d  = 1'b0;
    case (rd_idx)
      gcn_pkg::IDX_CN_EN_LO: rd_data_d[15:0] = cn_en_lo_q;
      gcn_pkg::IDX_CN_EN_HI: rd_data_d[7:0]  = cn_en_hi_q;
      gcn_pkg::IDX_CN_PU_LO: rd_data_d[15:0] = cn_pu_lo_q;
      gcn_pkg::IDX_CN_PU_HI: rd_data_d[7:0]  = cn_pu_hi_q;
      gcn_pkg::IDX_CN_STAT:  rd_data_d[0]    = cn_bus.irq;
      gcn_pkg::IDX_ANA_SEL:  rd_data_d[15:0] = analog_q;
      default:
      begin
        for (int i = 0; i < NP; i++)
          rd_data_d[15:0] = rd_data_d[15:0] | rd_val_w[i];
        rd_err_d = !(|rd_hit_w);
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= gcn_pkg::RESP_OKAY;
      rd_an_q   <= '0;
    end
    else
    begin
      arready_q <= !((arvalid && arready_q) || (rvalid_q && !rready));
      if (arvalid && arready_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data_d;
        rresp_q  <= rd_err_d ? gcn_pkg::RESP_SLVERR : gcn_pkg::RESP_OKAY;
        rd_an_q  <= (rd_idx == gcn_pkg::PIN_IDX[AP]) ? analog_q : 16'h0000;
      end
      else if (rready)
        rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Change detector; status bit 0 is write-one-to-clear

  assign cn_bus.en      = {cn_en_hi_q, cn_en_lo_q};
  assign cn_bus.sync_in = cn_sync_w;
  assign cn_bus.raw_in  = cn_pad_in;
  assign cn_bus.sleep   = sleep_mode;
  assign cn_bus.ack     = do_write && (wr_idx_q == gcn_pkg::IDX_CN_STAT) && wstrb_q[0] && wdata_q[0];

  gcn_change_detect u_cn (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (cn_bus)
  );

  // ==========================================================================
  // Outputs
  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign pad_out      = pad_out_q;
  assign pad_oe_n     = pad_oe_n_q;
  assign cn_pullup_en = {cn_pu_hi_q, cn_pu_lo_q};
  assign cn_irq       = cn_bus.irq;
  assign cn_wake      = cn_bus.wake;
  assign adc_chan_en  = analog_q;
  assign adc_level    = adc_level_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  dir_reset_a : assert property ($past(!aresetn) |-> dir_q == mask_w)
    else $error("direction not at implemented mask after reset");
  lat_reset_a : assert property ($past(!aresetn) |-> lat_q == '0)
    else $error("latch not zero after reset");
  unimpl_zero_a : assert property (((dir_q | lat_q) & ~mask_w) == '0)
    else $error("unimplemented bit holds a one");
  oe_input_a : assert property (1 |=> ((~pad_oe_n_q) & $past(dir_q & ~periph_drive)) == '0)
    else $error("input pin driven by port");
  periph_own_a : assert property (1 |=> ((pad_out_q ^ $past(periph_out)) & $past(periph_drive)) == '0)
    else $error("port drives a pin owned by a peripheral");
  analog_zero_a : assert property (rvalid_q |-> (rdata_q[15:0] & rd_an_q) == '0)
    else $error("analog pin read as one");
  adc_digital_a : assert property (1 |=> (adc_level_q & ~$past(analog_q)) == '0)
    else $error("digital pin level reached converter");
  adc_drive_a : assert property (1 |=>
    ((adc_level_q ^ $past(lat_q[AP])) & $past(analog_q & ~dir_q[AP] & ~periph_drive[AP])) == '0)
    else $error("converter did not see driven level");
  write_latch_a : assert property (do_write && wr_idx_q == gcn_pkg::PIN_IDX[AP] && wstrb_q == 4'hF
    |=> lat_q[AP] == ($past(wdata_q[15:0]) & mask_w[AP]))
    else $error("pin register write missed the latch");

  write_done_c : cover property (bvalid_q && bready);
  read_done_c : cover property (rvalid_q && rready && rresp_q == gcn_pkg::RESP_OKAY);
  unmapped_c : cover property (bvalid_q && bresp_q == gcn_pkg::RESP_SLVERR);
endmodule // gcn_top

// ---- sim/gcn_pad_model.sv ----
`timescale 1ns/10ps
// ====
// Pads and the outside world
module gcn_pad_model (
  // Device side
  input  wire gcn_pkg::gcn_port_vec_t pad_out,
  input  wire gcn_pkg::gcn_port_vec_t pad_oe_n,
  // Outside level on released pins
  input  wire gcn_pkg::gcn_port_vec_t ext,
  output wire gcn_pkg::gcn_port_vec_t pad_in
);
  // A released pin shows the outside level, never the last driven one
  assign pad_in = (pad_out & ~pad_oe_n) | (ext & pad_oe_n);
endmodule // gcn_pad_model

// ---- sim/gpio_ports_change_notify_tb_top.sv ----
`timescale 1ns/10ps
module gpio_ports_change_notify_tb_top;
  // ====
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, cn_irq, cn_wake, slp = 1'b0;
  logic [1:0] bresp, rresp, r;
  gcn_pkg::gcn_port_vec_t pad_in, pad_out, pad_oe_n, ext = '0, pdrv = '0, pout = '0;
  logic [23:0] cn_in = 24'h0, cn_pu;
  logic [15:0] d, lat, dir, ana, adc_en, adc_lvl;
  int mismatches = 0, tests_run = 0, cyc = 0;
  always #25 aclk = ~aclk;
  gcn_top i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .pad_in, .pad_out, .pad_oe_n, .periph_drive(pdrv), .periph_out(pout), .cn_pad_in(cn_in),
    .sleep_mode(slp), .cn_pullup_en(cn_pu), .cn_irq, .cn_wake, .adc_chan_en(adc_en), .adc_level(adc_lvl));
  gcn_pad_model i_pads (.pad_out, .pad_oe_n, .ext, .pad_in);
  // ====
  // Bus tasks and checks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [15:0] v);
    @(posedge aclk);
    awaddr  <= {i, 2'b00};
    wdata   <= {16'h0000, v};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i);
    @(posedge aclk);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  // Peripheral-driven pins read the peripheral, released ones the outside level, driven ones the latch
  function automatic logic [15:0] exp_pin(input int p);
    logic [15:0] v;
    v = (pout[p] & pdrv[p]) | (~pdrv[p] & ((ext[p] & dir) | (lat & ~dir)));
    return v & gcn_pkg::MASK_LARGE[p] & ~((p == 1) ? ana : 16'h0000);
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out;
    end
  end
  // ====
  // Tests
  initial
  begin
    void'($urandom(32'hf7d26221));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 6; p++)
    begin
      rd(gcn_pkg::DIR_IDX[p]);
      chk("dir", gcn_pkg::MASK_LARGE[p], d);
      rd(gcn_pkg::LAT_IDX[p]);
      chk("lat", 16'h0000, d);
    end
    $display("test reset done");
    ana = 16'($urandom);
    wr(gcn_pkg::IDX_ANA_SEL, ana);
    for (int p = 0; p < 6; p++)
    begin
      lat = 16'($urandom);
      dir = 16'($urandom);
      ext[p] <= 16'($urandom);
      wr(p[0] ? gcn_pkg::PIN_IDX[p] : gcn_pkg::LAT_IDX[p], lat);
      wr(gcn_pkg::DIR_IDX[p], dir);
      repeat (5) @(posedge aclk);
      rd(gcn_pkg::LAT_IDX[p]);
      chk("lat", lat & gcn_pkg::MASK_LARGE[p], d);
      rd(gcn_pkg::DIR_IDX[p]);
      chk("dir", dir & gcn_pkg::MASK_LARGE[p], d);
      rd(gcn_pkg::PIN_IDX[p]);
      chk("pin", exp_pin(p), d);
    end
    $display("test ports done");
    // Port G keeps its last settings; a peripheral now takes some of its pins
    pdrv[5] <= 16'($urandom);
    pout[5] <= 16'($urandom);
    repeat (5) @(posedge aclk);
    rd(gcn_pkg::PIN_IDX[5]);
    chk("pin_periph", exp_pin(5), d);
    $display("test periph done");
    for (int k = 0; k < 2; k++)
    begin
      wr(k ? gcn_pkg::IDX_CN_EN_HI : gcn_pkg::IDX_CN_EN_LO, 16'h0001);
      cn_in <= cn_in ^ 24'h000002;
      repeat (5) @(posedge aclk);
      chk("irq", 16'h0000, 16'(cn_irq));
      cn_in <= cn_in ^ (k ? 24'h010000 : 24'h000001);
      repeat (5) @(posedge aclk);
      chk("irq", 16'h0001, 16'(cn_irq));
      wr(gcn_pkg::IDX_CN_STAT, 16'h0001);
      chk("irq", 16'h0000, 16'(cn_irq));
    end
    $display("test change done");
    slp <= 1'b1;
    repeat (2) @(posedge aclk);
    cn_in <= cn_in ^ 24'h000001;
    repeat (2) @(posedge aclk);
    chk("wake", 16'h0001, 16'(cn_wake));
    slp <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("wake", 16'h0000, 16'(cn_wake));
    chk("irq", 16'h0001, 16'(cn_irq));
    wr(gcn_pkg::IDX_CN_STAT, 16'h0001);
    chk("irq", 16'h0000, 16'(cn_irq));
    $display("test sleep done");
    wr(gcn_pkg::DIR_IDX[1], 16'hFFFF);
    repeat (5) @(posedge aclk);
    chk("adc_en", ana, adc_en);
    chk("adc_in", ana & ext[1], adc_lvl);
    lat = 16'($urandom);
    dir = 16'h0000;
    wr(gcn_pkg::LAT_IDX[1], lat);
    wr(gcn_pkg::DIR_IDX[1], dir);
    repeat (5) @(posedge aclk);
    chk("adc_out", ana & lat, adc_lvl);
    rd(gcn_pkg::PIN_IDX[1]);
    chk("pin", exp_pin(1), d);
    $display("test analog done");
    lat = 16'($urandom);
    dir = 16'($urandom);
    wr(gcn_pkg::IDX_CN_PU_LO, lat);
    wr(gcn_pkg::IDX_CN_PU_HI, dir);
    chk("pu_lo", lat, cn_pu[15:0]);
    chk("pu_hi", {8'h00, dir[7:0]}, {8'h00, cn_pu[23:16]});
    $display("test pullup done");
    wr(10'h000, 16'h1234);
    chk("bresp", 16'(gcn_pkg::RESP_SLVERR), 16'(r));
    rd(10'h000);
    chk("rdata", 16'h0000, d);
    chk("rresp", 16'(gcn_pkg::RESP_SLVERR), 16'(r));
    $display("test unmapped done");
    close_out;
  end
endmodule // gpio_ports_change_notify_tb_top
